/* File: rtl/fdcapd_top.sv */
`timescale 1ns/10ps
`include "fdcapd_cfg.svh"
// Function
// - Auto powerdown allowed only while power config bit 7 is set.
// - Chip config zero bit 3 forces direct powerdown regardless.
// - Entry needs all motor enable bits zero.
// - Entry needs main status 80H and no pending command interrupt.
// - Entry needs the head unload timer expired.
// - Entry needs the 10 ms inactivity timer expired; all together.
// - Inactivity timer starts when auto powerdown is enabled.
// - Main status read or data port access reloads the timer.
// - Clearing the enable cancels timer and holds controller awake.
// - Rate-select powerdown overrides auto; auto resumes after it.
// - Reset pin or software reset wake runs the reset sequence.
// - Register-access wake keeps all state.
// - Setting a motor bit wakes; reading output control does not.
// - Main status read wakes.
// - Data port read or write wakes.
// - After wake timer reloads 10 ms; powers down again later.
// - Non-waking accesses keep powerdown, read true, retain writes.
// - Non-waking offsets 00H,01H,02H,04H write,07H.
// - Waking offsets 04H read and 05H.
// - Drive outputs disabled in powerdown; host side stays active.
// - One auto bit per logical device; direct bits for fdc and parallel only, uart ones tied to zero.
// - Output control or rate writes wake only for motor or reset.
module fdcapd_top #(
	parameter int unsigned IDLE_CYCLES = `FDCAPD_IDLE_CYC
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire fdcapd_pkg::fdcapd_host_t host_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] chip_config_zero_i,
	input wire logic [7:0] power_config_register_i,
	input wire logic [7:0] main_status_i,
	input wire logic [7:0] drive_status_a_i,
	input wire logic [7:0] drive_status_b_i,
	input wire logic [7:0] digital_input_status_i,
	input wire logic [7:0] data_fifo_rdata_i,
	input wire logic cmd_int_i,
	input wire logic head_unload_expired_i,
	input wire fdcapd_pkg::fdcapd_drive_t drive_i,
	output fdcapd_pkg::fdcapd_drive_t drive_o,
	output fdcapd_pkg::fdcapd_drive_t drive_oe_o,
	output logic [7:0] digital_output_control_o,
	output logic [7:0] data_rate_select_o,
	output logic [7:0] config_control_o,
	output logic [3:0] dev_direct_pd_o,
	output logic [3:0] dev_auto_en_o,
	output logic fdc_powered_down_o,
	output logic fdc_soft_reset_o
);
	import fdcapd_pkg::*;
	// Count is a parameter so a bench can shorten the 10 ms wait
	localparam logic [23:0] IDLE_RELOAD = 24'(IDLE_CYCLES);

	// ==========================================
	// Host access decode
	function automatic logic hit(input fdcapd_host_t h, input logic [2:0] a);
		hit = (h.addr == a);
	endfunction

	logic auto_en;
	logic rd_msr, data_acc, motor_set, sw_reset, wake, enter_ok;
	logic rate_pd_req;
	logic [23:0] idle_cnt_r;
	fdcapd_state_t state_r;
	logic [7:0] doc_r, dsr_r, ccr_r;

	assign auto_en = power_config_register_i[`FDCAPD_CR7_FDC_AUTO];
	assign rd_msr = host_i.rd && hit(host_i, `FDCAPD_OFS_RATE_MSR);
	assign data_acc = (host_i.rd || host_i.wr)
		&& hit(host_i, `FDCAPD_OFS_DATA);
	// A write turning a motor bit on wakes, as does one clearing the reset bit; reads never do
	assign motor_set = host_i.wr && hit(host_i, `FDCAPD_OFS_DOC)
		&& ((host_i.wdata[7:4] & ~doc_r[7:4]) != 4'h0);
	assign sw_reset = host_i.wr && (
		(hit(host_i, `FDCAPD_OFS_DOC)
		&& !host_i.wdata[`FDCAPD_DOC_RESET_N])
		|| (hit(host_i, `FDCAPD_OFS_RATE_MSR)
		&& host_i.wdata[`FDCAPD_DSR_SWRESET]));
	assign wake = rd_msr || data_acc || motor_set || sw_reset;
	assign rate_pd_req = host_i.wr && hit(host_i, `FDCAPD_OFS_RATE_MSR)
		&& host_i.wdata[`FDCAPD_DSR_POWERDOWN]
		&& !host_i.wdata[`FDCAPD_DSR_SWRESET];
	assign enter_ok = auto_en
		&& (doc_r[7:4] == 4'h0)
		&& (main_status_i == `FDCAPD_MSR_IDLE) && !cmd_int_i
		&& head_unload_expired_i
		&& (idle_cnt_r == 24'h0);

	// ==========================================
	// Registers retained across powerdown
	// Writes land even while powered down so state survives the wake
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			doc_r <= `FDCAPD_DOC_RESET;
		end else if (host_i.wr && hit(host_i, `FDCAPD_OFS_DOC)) begin
			doc_r <= host_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || sw_reset) begin
			dsr_r <= `FDCAPD_DSR_RESET;
		end else if (host_i.wr && hit(host_i, `FDCAPD_OFS_RATE_MSR)) begin
			dsr_r <= host_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ccr_r <= `FDCAPD_CCR_RESET;
		end else if (host_i.wr && hit(host_i, `FDCAPD_OFS_DIN_CCR)) begin
			ccr_r <= host_i.wdata;
		end
	end

	// ==========================================
	// Inactivity timer
	always_ff @(posedge clk_i) begin
		if (reset_i || !auto_en) begin
			idle_cnt_r <= IDLE_RELOAD;
		end else if (rd_msr || data_acc || wake) begin
			idle_cnt_r <= IDLE_RELOAD;
		end else if (idle_cnt_r != 24'h0) begin
			idle_cnt_r <= idle_cnt_r - 24'h1;
		end
	end

	// ==========================================
	// Power state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r <= FDCAPD_RUN;
		end else begin
			case (state_r)
				FDCAPD_RUN: begin
					if (rate_pd_req) begin
						state_r <= FDCAPD_RATE_PD;
					end else if (enter_ok && !wake) begin
						state_r <= FDCAPD_AUTO_PD;
					end
				end
				FDCAPD_AUTO_PD: begin
					if (rate_pd_req) begin
						state_r <= FDCAPD_RATE_PD;
					end else if (wake || !auto_en) begin
						state_r <= FDCAPD_RUN;
					end
				end
				FDCAPD_RATE_PD: begin
					if (wake) begin
						state_r <= FDCAPD_RUN;
					end
				end
				default: begin
					state_r <= FDCAPD_RUN;
				end
			endcase
		end
	end

	logic pd;
	assign pd = (state_r != FDCAPD_RUN)
		|| chip_config_zero_i[`FDCAPD_CR0_FDC_DIRECT];

	// ==========================================
	// Drive pin enables
	// One enable per tristated drive pin; all follow the power state
	logic [$bits(fdcapd_drive_t)-1:0] oe_nxt;
	genvar gi;
	generate
		for (gi = 0; gi < $bits(fdcapd_drive_t); gi = gi + 1) begin : g_oe
			assign oe_nxt[gi] = !pd;
		end
	endgenerate

	// ==========================================
	// Outputs
	// Drive pins tristate in powerdown; host read path stays live
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			drive_o <= '0;
			drive_oe_o <= '0;
			fdc_powered_down_o <= 1'b0;
			fdc_soft_reset_o <= 1'b0;
		end else begin
			drive_o <= drive_i;
			drive_oe_o <= oe_nxt;
			fdc_powered_down_o <= pd;
			fdc_soft_reset_o <= sw_reset;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else if (host_i.rd) begin
			case (host_i.addr)
				`FDCAPD_OFS_STATUS_A: rdata_o <= drive_status_a_i;
				`FDCAPD_OFS_STATUS_B: rdata_o <= drive_status_b_i;
				`FDCAPD_OFS_DOC: rdata_o <= doc_r;
				`FDCAPD_OFS_RATE_MSR: rdata_o <= main_status_i;
				`FDCAPD_OFS_DATA: rdata_o <= data_fifo_rdata_i;
				`FDCAPD_OFS_DIN_CCR: rdata_o <= digital_input_status_i;
				default: rdata_o <= 8'h00;
			endcase
		end
	end

	assign digital_output_control_o = doc_r;
	assign data_rate_select_o = dsr_r;
	assign config_control_o = ccr_r;
	// Per-device bits: fdc, uart1, uart2, parallel
	assign dev_auto_en_o = {power_config_register_i[`FDCAPD_CR7_PAR_AUTO],
		power_config_register_i[`FDCAPD_CR7_UART2_AUTO],
		power_config_register_i[`FDCAPD_CR7_UART1_AUTO],
		auto_en};
	assign dev_direct_pd_o = {chip_config_zero_i[2], 2'b00,
		chip_config_zero_i[`FDCAPD_CR0_FDC_DIRECT]};

	// ==========================================
	// Checks
	AST_DIRECT_PD: assert property (@(posedge clk_i) disable iff (reset_i)
		chip_config_zero_i[`FDCAPD_CR0_FDC_DIRECT] |=> fdc_powered_down_o)
		else $error("direct powerdown not shown");
	AST_NO_AUTO_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
		!auto_en |=> state_r != FDCAPD_AUTO_PD)
		else $error("auto powerdown while disabled");
	AST_ENTRY_COND: assert property (@(posedge clk_i) disable iff (reset_i)
		state_r == FDCAPD_RUN ##1 state_r == FDCAPD_AUTO_PD
		|-> $past(idle_cnt_r) == 24'h0 && $past(doc_r[7:4]) == 4'h0)
		else $error("entry without conditions");
	AST_RELOAD: assert property (@(posedge clk_i) disable iff (reset_i)
		auto_en && (rd_msr || data_acc)
		|=> idle_cnt_r == IDLE_RELOAD)
		else $error("timer not reloaded");
	AST_COUNT: assert property (@(posedge clk_i) disable iff (reset_i)
		auto_en && $past(auto_en) && !wake && idle_cnt_r != 24'h0
		|=> idle_cnt_r == $past(idle_cnt_r) - 24'h1)
		else $error("timer not counting");
	AST_WAKE: assert property (@(posedge clk_i) disable iff (reset_i)
		state_r == FDCAPD_AUTO_PD && wake && !rate_pd_req
		|=> state_r == FDCAPD_RUN)
		else $error("wake ignored");
	AST_WAKE_WINS: assert property (@(posedge clk_i) disable iff (reset_i)
		state_r == FDCAPD_RUN && wake |=> state_r != FDCAPD_AUTO_PD)
		else $error("entered despite wake");
	AST_TRISTATE: assert property (@(posedge clk_i) disable iff (reset_i)
		state_r != FDCAPD_RUN |=> drive_oe_o == '0)
		else $error("drive pins enabled in powerdown");
	AST_DOC_READ: assert property (@(posedge clk_i) disable iff (reset_i)
		state_r == FDCAPD_AUTO_PD && host_i.rd && !rd_msr && !data_acc
		&& auto_en |=> state_r == FDCAPD_AUTO_PD)
		else $error("non-waking read woke the part");

	// ==========================================
	// Entry, exit, timer, soft reset, register and output checks

	AST_MOTOR_BLOCK: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_RUN && doc_r[7:4] != 4'h0
		|=> state_r != FDCAPD_AUTO_PD)
		else $error("entry with a motor on");

	AST_BUSY_BLOCK: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_RUN && cmd_int_i
		|=> state_r != FDCAPD_AUTO_PD)
		else $error("entry with interrupt pending");

	AST_HEAD_BLOCK: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_RUN && !head_unload_expired_i
		|=> state_r != FDCAPD_AUTO_PD)
		else $error("entry before head unload");

	AST_TIMER_BLOCK: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_RUN && idle_cnt_r != 24'h0
		|=> state_r != FDCAPD_AUTO_PD)
		else $error("entry before timer expiry");

	AST_ENTRY_GO: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_RUN && enter_ok
		&& !wake && !rate_pd_req |=> state_r == FDCAPD_AUTO_PD)
		else $error("no entry with all conditions met");

	AST_DISABLE_RELOAD: assert property (@(posedge clk_i)
		disable iff (reset_i) !auto_en
		|=> idle_cnt_r == IDLE_RELOAD)
		else $error("timer runs while disabled");

	AST_DISABLE_EXIT: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_AUTO_PD && !auto_en
		&& !rate_pd_req |=> state_r == FDCAPD_RUN)
		else $error("auto powerdown kept after disable");

	AST_RATE_ENTER: assert property (@(posedge clk_i)
		disable iff (reset_i) rate_pd_req && !wake
		|=> state_r == FDCAPD_RATE_PD)
		else $error("rate powerdown not taken");

	AST_RATE_EXIT: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_RATE_PD && wake
		|=> state_r == FDCAPD_RUN)
		else $error("rate powerdown not left on wake");

	AST_RATE_HOLD: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_RATE_PD && !wake
		|=> state_r == FDCAPD_RATE_PD)
		else $error("rate powerdown left without wake");

	AST_SWRESET_PULSE: assert property (@(posedge clk_i)
		disable iff (reset_i) sw_reset
		|=> fdc_soft_reset_o)
		else $error("soft reset pulse missing");

	AST_SWRESET_DSR: assert property (@(posedge clk_i)
		disable iff (reset_i) sw_reset
		|=> data_rate_select_o == `FDCAPD_DSR_RESET)
		else $error("rate select not reset");

	AST_DOC_HOLD: assert property (@(posedge clk_i)
		disable iff (reset_i) !(host_i.wr && hit(host_i, `FDCAPD_OFS_DOC))
		|=> $stable(digital_output_control_o))
		else $error("output control changed unwritten");

	AST_PD_CLEAR: assert property (@(posedge clk_i)
		disable iff (reset_i) !pd
		|=> !fdc_powered_down_o)
		else $error("powered down shown while running");

	AST_MOTOR_WAKE: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_AUTO_PD && motor_set
		|=> state_r == FDCAPD_RUN)
		else $error("motor enable did not wake");

	AST_DATA_WAKE: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_AUTO_PD && data_acc
		|=> state_r == FDCAPD_RUN)
		else $error("data port access did not wake");

	AST_REARM: assert property (@(posedge clk_i)
		disable iff (reset_i) auto_en && wake
		|=> idle_cnt_r == IDLE_RELOAD)
		else $error("timer not rearmed on wake");

	AST_NONWAKE_WRITE: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_AUTO_PD && auto_en
		&& host_i.wr && hit(host_i, `FDCAPD_OFS_DIN_CCR)
		|=> state_r == FDCAPD_AUTO_PD && config_control_o == $past(host_i.wdata))
		else $error("config write woke or was lost");

	AST_READ_TRUE: assert property (@(posedge clk_i)
		disable iff (reset_i) host_i.rd && hit(host_i, `FDCAPD_OFS_STATUS_A)
		|=> rdata_o == $past(drive_status_a_i))
		else $error("status A read wrong");

	AST_MSR_READ: assert property (@(posedge clk_i)
		disable iff (reset_i) rd_msr
		|=> rdata_o == $past(main_status_i))
		else $error("main status read wrong");

	AST_DRIVE_COPY: assert property (@(posedge clk_i)
		disable iff (reset_i) 1'b1
		|=> drive_o == $past(drive_i))
		else $error("drive values not passed");

	AST_OE_RUN: assert property (@(posedge clk_i)
		disable iff (reset_i) !pd
		|=> drive_oe_o == '1)
		else $error("drive pins off while running");

	AST_DOC_WRITE_NOWAKE: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r == FDCAPD_AUTO_PD && auto_en
		&& host_i.wr && hit(host_i, `FDCAPD_OFS_DOC) && !wake
		|=> state_r == FDCAPD_AUTO_PD)
		else $error("plain output control write woke");

	AST_PD_LAG: assert property (@(posedge clk_i)
		disable iff (reset_i) state_r != FDCAPD_RUN
		|=> fdc_powered_down_o)
		else $error("powerdown not shown");
endmodule

/* File: rtl/fdcapd_cfg.svh */
`ifndef FDCAPD_CFG_SVH
`define FDCAPD_CFG_SVH
`define FDCAPD_OFS_STATUS_A 3'h0
`define FDCAPD_OFS_STATUS_B 3'h1
`define FDCAPD_OFS_DOC 3'h2
`define FDCAPD_OFS_RATE_MSR 3'h4
`define FDCAPD_OFS_DATA 3'h5
`define FDCAPD_OFS_DIN_CCR 3'h7
`define FDCAPD_CR7_FDC_AUTO 7
`define FDCAPD_CR7_UART1_AUTO 5
`define FDCAPD_CR7_UART2_AUTO 6
`define FDCAPD_CR7_PAR_AUTO 4
`define FDCAPD_CR0_FDC_DIRECT 3
`define FDCAPD_DOC_MOTOR_LO 4
`define FDCAPD_DOC_RESET_N 2
`define FDCAPD_DSR_SWRESET 7
`define FDCAPD_DSR_POWERDOWN 6
`define FDCAPD_MSR_IDLE 8'h80
`define FDCAPD_DOC_RESET 8'h00
`define FDCAPD_DSR_RESET 8'h02
`define FDCAPD_CCR_RESET 8'h02
`define FDCAPD_IDLE_MS 10
`define FDCAPD_CLK_MHZ 100
`define FDCAPD_IDLE_CYC (`FDCAPD_IDLE_MS * 1000 * `FDCAPD_CLK_MHZ)
`endif

/* File: rtl/fdcapd_pkg.sv */
package fdcapd_pkg;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} fdcapd_host_t;
	typedef struct packed {
		logic [3:0] moten;
		logic [3:0] dsel;
		logic wrdata;
		logic we;
	} fdcapd_drive_t;
	typedef enum logic [1:0] {
		FDCAPD_RUN = 2'b00,
		FDCAPD_AUTO_PD = 2'b01,
		FDCAPD_RATE_PD = 2'b10
	} fdcapd_state_t;
endpackage

/* File: tb/fdcapd_host_bfm.sv */
`timescale 1ns/10ps
// ==============================
// Host processor model on the I/O bus
module fdcapd_host_bfm (
	input wire logic clk_i,
	output fdcapd_pkg::fdcapd_host_t host_o,
	input wire logic [7:0] rdata_i
);
	import fdcapd_pkg::*;
	initial host_o = '0;
	// Strobe lasts one cycle; released lines show inverted values
	task automatic access(input logic wr, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_i);
		host_o = '{rd: !wr, wr: wr, addr: a, wdata: d};
		@(negedge clk_i);
		host_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
		@(negedge clk_i);
		q = rdata_i;
	endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`include "fdcapd_cfg.svh"
module tb_top;
	import fdcapd_pkg::*;
	logic clk_i, reset_i, cmd_int, hu_exp, pd, srst;
	logic [7:0] cr0, cr7, main_status, drive_status_a, drive_status_b, din, fifo, rdata, doc, dsr, config_control, q;
	logic [3:0] dpd, aen;
	fdcapd_host_t host;
	fdcapd_drive_t drv_in, drv, drv_oe;
	int bad_count, n_checks, cyc, n;
	// Short idle count keeps the run small; the design scales with it
	localparam int TB_IDLE = 2000;
	fdcapd_host_bfm host_m (.clk_i(clk_i), .host_o(host), .rdata_i(rdata));
	fdcapd_top #(.IDLE_CYCLES(TB_IDLE)) uut (.clk_i(clk_i),
		.reset_i(reset_i), .host_i(host),
		.rdata_o(rdata), .chip_config_zero_i(cr0),
		.power_config_register_i(cr7), .main_status_i(main_status),
		.drive_status_a_i(drive_status_a), .drive_status_b_i(drive_status_b),
		.digital_input_status_i(din), .data_fifo_rdata_i(fifo),
		.cmd_int_i(cmd_int), .head_unload_expired_i(hu_exp),
		.drive_i(drv_in), .drive_o(drv), .drive_oe_o(drv_oe),
		.digital_output_control_o(doc), .data_rate_select_o(dsr),
		.config_control_o(config_control), .dev_direct_pd_o(dpd),
		.dev_auto_en_o(aen), .fdc_powered_down_o(pd),
		.fdc_soft_reset_o(srst));
	// ==============================
	// Checking and closing
	task automatic chk(input string nm, input logic [9:0] seen,
		input logic [9:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wait_n(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	// ==============================
	// Scenarios
	task automatic t_reset();
		chk("doc", doc, 10'h000);
		chk("dsr", dsr, 10'h002);
		chk("ccr", config_control, 10'h002);
		chk("pd", pd, 10'h000);
		chk("drv", drv, drv_in);
	endtask
	task automatic t_direct();
		cr0 = 8'h08;
		wait_n(3);
		chk("pd", pd, 10'h001);
		chk("dpd", dpd[0], 10'h001);
		chk("oe", drv_oe, 10'h000);
		host_m.access(1'b0, 3'h0, 8'h00, q);
		chk("sra", q, drive_status_a);
		cr0 = 8'h00;
		wait_n(3);
		chk("pd", pd, 10'h000);
		chk("oe", drv_oe, 10'h3FF);
	endtask
	task automatic t_rate();
		host_m.access(1'b1, `FDCAPD_OFS_RATE_MSR, 8'h40, q);
		wait_n(1);
		chk("pd", pd, 10'h001);
		chk("dsr", dsr, 10'h040);
		host_m.access(1'b1, `FDCAPD_OFS_DOC, 8'h1C, q);
		chk("pd", pd, 10'h000);
		chk("doc", doc, 10'h01C);
		host_m.access(1'b1, `FDCAPD_OFS_RATE_MSR, 8'h82, q);
		chk("dsr", dsr, 10'h002);
		host_m.access(1'b1, `FDCAPD_OFS_DOC, 8'h0C, q);
	endtask
	task automatic t_auto();
		cmd_int = 1'b1;
		cr7 = 8'hF0;
		wait_n(2);
		chk("aen", aen, 10'h00F);
		wait_n(1000);
		host_m.access(1'b0, 3'h5, 8'h00, q);
		chk("fifo", q, fifo);
		wait_n(500);
		chk("pd", pd, 10'h000);
		cmd_int = 1'b0;
		n = 0;
		// Reload by the data read must push entry a full period out
		while (pd !== 1'b1 && n < TB_IDLE + 50) begin
			@(negedge clk_i);
			n++;
		end
		chk("pd", pd, 10'h001);
		chk("late", n > TB_IDLE - 600, 10'h001);
		chk("oe", drv_oe, 10'h000);
		host_m.access(1'b0, 3'h1, 8'h00, q);
		chk("srb", q, drive_status_b);
		host_m.access(1'b1, 3'h2, 8'h0C, q);
		host_m.access(1'b0, 3'h2, 8'h00, q);
		chk("docr", q, 10'h00C);
		wait_n(2);
		chk("pd", pd, 10'h001);
		host_m.access(1'b0, 3'h4, 8'h00, q);
		chk("msr", q, main_status);
		chk("pd", pd, 10'h000);
		chk("oe", drv_oe, 10'h3FF);
		chk("doc", doc, 10'h00C);
		hu_exp = 1'b0;
		wait_n(TB_IDLE + 100);
		chk("pd", pd, 10'h000);
		hu_exp = 1'b1;
		wait_n(4);
		chk("pd", pd, 10'h001);
		host_m.access(1'b1, 3'h5, 8'h00, q);
		chk("pd", pd, 10'h000);
		cr7 = 8'h00;
		wait_n(3000);
		chk("pd", pd, 10'h000);
	endtask
	// ==============================
	// Clock, reset, timeout and main sequence
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		{bad_count, n_checks, cyc} = '0;
		{cmd_int, cr0, cr7} = '0;
		reset_i = 1'b1;
		hu_exp = 1'b1;
		{main_status, drive_status_a, drive_status_b, din, fifo} = {8'h80, 8'h5A, 8'hA6, 8'h3C, 8'hC3};
		drv_in = 10'h155;
		wait_n(20);
		reset_i = 1'b0;
		wait_n(2);
		t_reset();
		t_direct();
		t_rate();
		t_auto();
		summarize();
	end
endmodule
